// ===== rtl/hbma_top.sv
// buffer memory arbiter: cpu address decode, ram sharing and completion interrupt
`timescale 1ns/1ps
module hbma_top #(
  parameter int RAM_DEPTH = 8192
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic cpu_req_in,
  input wire logic cpu_we_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic [31:0] cpu_wdata_in,
  output logic [31:0] cpu_rdata_out,
  output logic cpu_rvalid_out,
  output logic cpu_err_out,
  output logic cpu_overrun_out,
  output logic [2:0] cpu_region_out,
  output logic [hbma_pkg::TD_IDX_W-1:0] cpu_td_index_out,
  input wire logic usb_req_in,
  input wire logic usb_we_in,
  input wire logic [hbma_pkg::RAM_AW-1:0] usb_addr_in,
  input wire logic [1:0] usb_dw_en_in,
  input wire logic [hbma_pkg::RAM_DW-1:0] usb_wdata_in,
  output logic usb_gnt_out,
  output logic [hbma_pkg::RAM_DW-1:0] usb_rdata_out,
  output logic usb_rvalid_out,
  input wire logic usb_td_done_in,
  input wire logic [1:0] usb_td_type_in,
  input wire logic [hbma_pkg::TD_IDX_W-1:0] usb_td_index_in,
  input wire logic [hbma_pkg::N_DONE-1:0] done_clear_in,
  input wire logic [hbma_pkg::N_DONE-1:0] irq_or_mask_in,
  input wire logic [hbma_pkg::N_DONE-1:0] irq_and_mask_in,
  output logic [hbma_pkg::N_DONE-1:0] done_status_out,
  output logic irq_out
);
  // ***********************************************************************
  // cpu address decode
  // ***********************************************************************
  logic [15:0] cpu_off;
  logic cpu_in_buf;
  logic cpu_aligned;
  logic [2:0] next_region;
  logic [hbma_pkg::RAM_AW-1:0] cpu_word;
  logic cpu_lane;

  assign cpu_off = cpu_addr_in - hbma_pkg::BUF_BASE;
  assign cpu_in_buf = (cpu_addr_in >= hbma_pkg::BUF_BASE) && (cpu_addr_in <= hbma_pkg::BUF_LAST);
  assign cpu_aligned = (cpu_addr_in[1:0] == 2'b00);
  assign cpu_word = cpu_off[hbma_pkg::WORD_SHIFT +: hbma_pkg::RAM_AW];
  assign cpu_lane = cpu_off[hbma_pkg::LANE_BIT];

  always_comb begin
    if (!cpu_in_buf) begin
      next_region = hbma_pkg::REG_AREA;
    end else if (cpu_addr_in >= hbma_pkg::PAYLOAD_BASE) begin
      next_region = hbma_pkg::PAYLOAD_AREA;
    end else if (cpu_addr_in >= hbma_pkg::ASYNC_BASE) begin
      next_region = hbma_pkg::ASYNC_LIST_AREA;
    end else if (cpu_addr_in >= hbma_pkg::INT_BASE) begin
      next_region = hbma_pkg::INT_AREA;
    end else begin
      next_region = hbma_pkg::ISO_AREA;
    end
  end

  // ***********************************************************************
  // posted cpu request slot
  // ***********************************************************************
  // no ready line back to the processor, so a request is held here until granted
  logic cpu_pend;
  logic cpu_pend_we;
  logic cpu_pend_lane;
  logic [hbma_pkg::RAM_AW-1:0] cpu_pend_word;
  logic [31:0] cpu_pend_data;
  logic cpu_accept;
  logic cpu_win;
  logic usb_win;
  hbma_pkg::hbma_owner_e last_owner;

  assign cpu_accept = cpu_req_in && cpu_in_buf && cpu_aligned && !(cpu_pend && !cpu_win);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cpu_pend <= 1'b0;
    end else if (cpu_accept) begin
      cpu_pend <= 1'b1;
    end else if (cpu_win) begin
      cpu_pend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cpu_pend_we <= 1'b0;
      cpu_pend_lane <= 1'b0;
      cpu_pend_word <= '0;
      cpu_pend_data <= 32'h0000_0000;
    end else if (cpu_accept) begin
      cpu_pend_we <= cpu_we_in;
      cpu_pend_lane <= cpu_lane;
      cpu_pend_word <= cpu_word;
      cpu_pend_data <= cpu_wdata_in;
    end
  end

  // every cpu request gets a decode answer the next cycle, even if refused
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cpu_err_out <= 1'b0;
      cpu_overrun_out <= 1'b0;
      cpu_region_out <= hbma_pkg::REG_AREA;
      cpu_td_index_out <= '0;
    end else begin
      cpu_err_out <= cpu_req_in && !(cpu_in_buf && cpu_aligned);
      cpu_overrun_out <= cpu_req_in && cpu_in_buf && cpu_aligned && cpu_pend && !cpu_win;
      if (cpu_req_in) begin
        cpu_region_out <= next_region;
        cpu_td_index_out <= cpu_off[hbma_pkg::TD_IDX_LSB +: hbma_pkg::TD_IDX_W];
      end
    end
  end

  // ***********************************************************************
  // arbiter
  // ***********************************************************************
  always_comb begin
    if (cpu_pend && usb_req_in) begin
      cpu_win = (last_owner == hbma_pkg::OWN_USB);
    end else begin
      cpu_win = cpu_pend;
    end
  end
  assign usb_win = usb_req_in && !cpu_win;
  assign usb_gnt_out = usb_win;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      last_owner <= hbma_pkg::OWN_USB;
    end else if (cpu_win) begin
      last_owner <= hbma_pkg::OWN_CPU;
    end else if (usb_win) begin
      last_owner <= hbma_pkg::OWN_USB;
    end
  end

  // ***********************************************************************
  // ram port
  // ***********************************************************************
  hbma_ram_if ram_bus ();

  always_comb begin
    ram_bus.en = cpu_win || usb_win;
    ram_bus.we = cpu_win ? cpu_pend_we : usb_we_in;
    ram_bus.addr = cpu_win ? cpu_pend_word : usb_addr_in;
    if (cpu_win) begin
      ram_bus.dw_en = cpu_pend_lane ? 2'b10 : 2'b01;
      ram_bus.wdata = {cpu_pend_data, cpu_pend_data};
    end else begin
      ram_bus.dw_en = usb_dw_en_in;
      ram_bus.wdata = usb_wdata_in;
    end
  end

  hbma_ram #(
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .ref_clk_in(ref_clk_in),
    .ram(ram_bus.mem)
  );

  // ***********************************************************************
  // read return
  // ***********************************************************************
  logic cpu_rd_q;
  logic cpu_lane_q;
  logic usb_rd_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cpu_rd_q <= 1'b0;
      cpu_lane_q <= 1'b0;
      usb_rd_q <= 1'b0;
    end else begin
      cpu_rd_q <= cpu_win && !cpu_pend_we;
      cpu_lane_q <= cpu_pend_lane;
      usb_rd_q <= usb_win && !usb_we_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cpu_rvalid_out <= 1'b0;
      cpu_rdata_out <= 32'h0000_0000;
    end else begin
      cpu_rvalid_out <= cpu_rd_q;
      if (cpu_rd_q) begin
        cpu_rdata_out <= cpu_lane_q ? ram_bus.rdata[63:32] : ram_bus.rdata[31:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      usb_rvalid_out <= 1'b0;
      usb_rdata_out <= '0;
    end else begin
      usb_rvalid_out <= usb_rd_q;
      if (usb_rd_q) begin
        usb_rdata_out <= ram_bus.rdata;
      end
    end
  end

  // ***********************************************************************
  // descriptor completion and interrupt
  // ***********************************************************************
  logic [hbma_pkg::N_DONE-1:0] done_set;
  logic [hbma_pkg::N_DONE-1:0] done_q;
  logic [6:0] done_bit;
  logic and_hit;
  logic or_hit;

  assign done_bit = {usb_td_type_in, usb_td_index_in};

  for (genvar g = 0; g < hbma_pkg::N_DONE; g++) begin : g_done
    assign done_set[g] = usb_td_done_in && (usb_td_type_in != 2'b11) && (done_bit == 7'(g));
    always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
        done_q[g] <= 1'b0;
      end else if (done_set[g]) begin
        done_q[g] <= 1'b1; // set wins over a clear in the same cycle
      end else if (done_clear_in[g]) begin
        done_q[g] <= 1'b0;
      end
    end
  end

  assign or_hit = |(done_q & irq_or_mask_in);
  assign and_hit = (|irq_and_mask_in) && ((done_q & irq_and_mask_in) == irq_and_mask_in);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= or_hit || and_hit;
    end
  end

  assign done_status_out = done_q;
endmodule : hbma_top

// ===== include/hbma_pkg.sv
// constants for the host buffer memory arbiter
package hbma_pkg;
  // ***********************************************************************
  // cpu address map
  // ***********************************************************************
  localparam logic [15:0] BUF_BASE = 16'h0400;
  localparam logic [15:0] BUF_LAST = 16'hffff;
  localparam logic [15:0] ISO_BASE = 16'h0400;
  localparam logic [15:0] INT_BASE = 16'h0800;
  localparam logic [15:0] ASYNC_BASE = 16'h0c00;
  localparam logic [15:0] PAYLOAD_BASE = 16'h1000;
  localparam int RAM_AW = 13;
  localparam int RAM_DW = 64;
  localparam int WORD_SHIFT = 3;
  localparam int LANE_BIT = 2;
  localparam int TD_PER_TYPE = 32;
  localparam int TD_DWORDS = 8;
  localparam int TD_BYTES = TD_DWORDS * 4;
  localparam int TD_IDX_W = 5;
  localparam int TD_IDX_LSB = 5;
  localparam int N_TYPES = 3;
  localparam int N_DONE = N_TYPES * TD_PER_TYPE;
  // ***********************************************************************
  // timing: one 64-bit word per clock at 10 MHz
  // ***********************************************************************
  localparam int CLK_MHZ = 10;
  localparam int RAM_BYTES_PER_CLK = RAM_DW / 8;
  localparam int TARGET_MBPS = 240;
  localparam int PEAK_MBPS = CLK_MHZ * RAM_BYTES_PER_CLK;
  localparam int CLK_MHZ_FOR_TARGET = (TARGET_MBPS + RAM_BYTES_PER_CLK - 1) / RAM_BYTES_PER_CLK;
  // ***********************************************************************
  // enumerations
  // ***********************************************************************
  typedef enum logic [2:0] {
    REG_AREA = 3'h0,
    ISO_AREA = 3'h1,
    INT_AREA = 3'h3,
    ASYNC_LIST_AREA = 3'h2,
    PAYLOAD_AREA = 3'h6
  } hbma_region_e;
  typedef enum logic {
    OWN_CPU = 1'b0,
    OWN_USB = 1'b1
  } hbma_owner_e;
endpackage : hbma_pkg

// ===== include/hbma_ram_if.sv
// port bundle between the arbiter and the buffer ram
`timescale 1ns/1ps
interface hbma_ram_if;
  logic en;
  logic we;
  logic [1:0] dw_en;
  logic [hbma_pkg::RAM_AW-1:0] addr;
  logic [hbma_pkg::RAM_DW-1:0] wdata;
  logic [hbma_pkg::RAM_DW-1:0] rdata;
  modport ctrl (output en, output we, output dw_en, output addr, output wdata, input rdata);
  modport mem (input en, input we, input dw_en, input addr, input wdata, output rdata);
endinterface : hbma_ram_if

// ===== rtl/hbma_ram.sv
// single-port 64-bit buffer ram with per double-word write enables
`timescale 1ns/1ps
module hbma_ram #(
  parameter int DEPTH = 8192
) (
  input wire logic ref_clk_in,
  hbma_ram_if.mem ram
);
  // ***********************************************************************
  // storage, one double-word lane per generate entry
  // ***********************************************************************
  // each lane owns its array, so no two processes ever write the same array
  for (genvar g = 0; g < 2; g++) begin : g_lane
    logic [31:0] mem [DEPTH];
    always_ff @(posedge ref_clk_in) begin
      if (ram.en && ram.we && ram.dw_en[g]) begin
        mem[ram.addr] <= ram.wdata[32*g +: 32];
      end
    end
    always_ff @(posedge ref_clk_in) begin
      if (ram.en && !ram.we) begin
        ram.rdata[32*g +: 32] <= mem[ram.addr];
      end
    end
  end
endmodule : hbma_ram

// ===== sim/hbma_asserts.sv
// concurrent checks on the buffer memory arbiter ports
`timescale 1ns/1ps
module hbma_asserts (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic cpu_req_in,
  input wire logic cpu_we_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_rvalid_out,
  input wire logic cpu_err_out,
  input wire logic cpu_overrun_out,
  input wire logic [2:0] cpu_region_out,
  input wire logic [4:0] cpu_td_index_out,
  input wire logic usb_req_in,
  input wire logic usb_we_in,
  input wire logic usb_gnt_out,
  input wire logic usb_rvalid_out,
  input wire logic usb_td_done_in,
  input wire logic [1:0] usb_td_type_in,
  input wire logic [4:0] usb_td_index_in,
  input wire logic [95:0] irq_or_mask_in,
  input wire logic [95:0] done_status_out,
  input wire logic irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic ok;
  logic [6:0] done_bit;
  logic [4:0] idx_q;
  assign ok = cpu_req_in && cpu_addr_in >= 16'h0400 && cpu_addr_in[1:0] == 2'b00;
  always_ff @(posedge ref_clk_in) begin
    done_bit <= {usb_td_type_in, usb_td_index_in};
    idx_q <= cpu_addr_in[9:5];
  end
  property p_err; cpu_req_in && !ok |=> cpu_err_out; endproperty
  a_err: assert property (p_err) else $error("refused access not flagged");
  property p_no_err; ok |=> !cpu_err_out; endproperty
  a_no_err: assert property (p_no_err) else $error("aligned access flagged");
  property p_payload; ok && cpu_addr_in >= 16'h1000 |=> cpu_region_out == 3'h6; endproperty
  a_payload: assert property (p_payload) else $error("payload region wrong");
  property p_index; ok && cpu_addr_in < 16'h1000 |=> cpu_td_index_out == idx_q; endproperty
  a_index: assert property (p_index) else $error("descriptor index wrong");
  property p_rd_lat; ok && !cpu_we_in ##1 !cpu_overrun_out |-> ##[2:3] cpu_rvalid_out; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("cpu read answer late");
  property p_usb_rd; usb_req_in && usb_gnt_out && !usb_we_in |-> ##2 usb_rvalid_out; endproperty
  a_usb_rd: assert property (p_usb_rd) else $error("usb read answer late");
  property p_fair; usb_req_in && !usb_gnt_out ##1 usb_req_in |-> usb_gnt_out; endproperty
  a_fair: assert property (p_fair) else $error("usb denied twice");
  property p_done; usb_td_done_in && usb_td_type_in != 2'h3 |=> done_status_out[done_bit]; endproperty
  a_done: assert property (p_done) else $error("completion bit not set");
  property p_irq; |(done_status_out & irq_or_mask_in) |=> irq_out; endproperty
  a_irq: assert property (p_irq) else $error("or-mask interrupt missing");
  c_tie: cover property (usb_req_in && !usb_gnt_out);
  c_err: cover property (cpu_err_out);
  c_irq: cover property ($rose(irq_out));
endmodule : hbma_asserts
bind hbma_top hbma_asserts u_chk (.ref_clk_in, .reset_in, .cpu_req_in, .cpu_we_in, .cpu_addr_in,
  .cpu_rvalid_out, .cpu_err_out, .cpu_overrun_out, .cpu_region_out, .cpu_td_index_out, .usb_req_in,
  .usb_we_in, .usb_gnt_out, .usb_rvalid_out, .usb_td_done_in, .usb_td_type_in, .usb_td_index_in,
  .irq_or_mask_in, .done_status_out, .irq_out);

// ===== sim/hbma_cpu_model.sv
// processor model: posts one slave access at a time, never masters the bus
`timescale 1ns/1ps
module hbma_cpu_model (
  input wire logic clk_in,
  output logic req_out,
  output logic we_out,
  output logic [15:0] addr_out,
  output logic [31:0] wdata_out
);
  initial begin
    req_out = 1'b0;
    we_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 32'h0;
  end
  // called at a falling edge; one-cycle request, released lines keep moving
  task automatic access(input logic we, input logic [15:0] addr, input logic [31:0] data);
    req_out = 1'b1;
    we_out = we;
    addr_out = addr;
    wdata_out = data;
    @(negedge clk_in);
    req_out = 1'b0;
    addr_out = ~addr;
    wdata_out = ~data;
  endtask : access
endmodule : hbma_cpu_model

// ===== sim/tb.sv
// self-checking bench for the buffer memory arbiter
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cpu_req_in, cpu_we_in, cpu_rvalid_out, cpu_err_out, cpu_overrun_out, usb_gnt_out, usb_rvalid_out, irq_out;
  logic [15:0] cpu_addr_in;
  logic [31:0] cpu_wdata_in, cpu_rdata_out, e32;
  logic [2:0] cpu_region_out;
  logic [4:0] cpu_td_index_out, usb_td_index_in = 5'h0;
  logic usb_req_in = 1'b0, usb_we_in = 1'b0, usb_td_done_in = 1'b0;
  logic [12:0] usb_addr_in = 13'h0;
  logic [1:0] usb_dw_en_in = 2'h0, usb_td_type_in = 2'h0;
  logic [63:0] usb_wdata_in = 64'h0, usb_rdata_out, e64;
  logic [95:0] done_clear_in = 96'h0, irq_or_mask_in = 96'h0, irq_and_mask_in = 96'h0;
  logic [95:0] done_status_out, exp_st = 96'h0;
  logic [31:0] shadow [logic [15:0]];
  logic [31:0] cpu_q [$];
  logic [63:0] usb_q [$];
  logic [15:0] amap [6] = '{16'h0404, 16'h0be0, 16'h0c3c, 16'h1000, 16'hfff8, 16'hfffc};
  int n_errors = 0, cmp_count = 0, k;
  hbma_top #(.RAM_DEPTH(8192)) DUT (.ref_clk_in, .reset_in, .cpu_req_in, .cpu_we_in, .cpu_addr_in,
    .cpu_wdata_in, .cpu_rdata_out, .cpu_rvalid_out, .cpu_err_out, .cpu_overrun_out, .cpu_region_out,
    .cpu_td_index_out, .usb_req_in, .usb_we_in, .usb_addr_in, .usb_dw_en_in, .usb_wdata_in, .usb_gnt_out,
    .usb_rdata_out, .usb_rvalid_out, .usb_td_done_in, .usb_td_type_in, .usb_td_index_in, .done_clear_in,
    .irq_or_mask_in, .irq_and_mask_in, .done_status_out, .irq_out);
  hbma_cpu_model cpu_m (.clk_in(ref_clk_in), .req_out(cpu_req_in), .we_out(cpu_we_in),
    .addr_out(cpu_addr_in), .wdata_out(cpu_wdata_in));
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [2:0] reg_of(input logic [15:0] a);
    if (a >= 16'h1000) return hbma_pkg::PAYLOAD_AREA;
    if (a[11:10] == 2'b01) return hbma_pkg::ISO_AREA;
    return (a[11:10] == 2'b10) ? hbma_pkg::INT_AREA : hbma_pkg::ASYNC_LIST_AREA;
  endfunction : reg_of
  // ***********************************************************************
  // drivers: all called at a falling edge
  // ***********************************************************************
  task automatic cpu(input logic we, input logic [15:0] a, input logic [31:0] d);
    logic bad;
    bad = (a < 16'h0400) || (a[1:0] != 2'b00);
    if (!we && !bad) cpu_q.push_back(shadow[a]);
    if (we && !bad) shadow[a] = d;
    cpu_m.access(we, a, d);
    `CHK("cpu_err", bad, cpu_err_out)
    `CHK("cpu_overrun", 1'b0, cpu_overrun_out)
    if (!bad) begin
      `CHK("region", reg_of(a), cpu_region_out)
      `CHK("td_index", a[9:5], cpu_td_index_out)
    end
    repeat (2) @(negedge ref_clk_in);
  endtask : cpu
  task automatic usb(input logic we, input logic [12:0] a, input logic [1:0] en, input logic [63:0] d);
    logic [15:0] c;
    logic g;
    int n;
    c = {a, 3'b000} + 16'h0400;
    if (!we) usb_q.push_back({shadow[c + 16'h4], shadow[c]});
    if (we && en[0]) shadow[c] = d[31:0];
    if (we && en[1]) shadow[c + 16'h4] = d[63:32];
    {usb_req_in, usb_we_in, usb_addr_in, usb_dw_en_in, usb_wdata_in} = {1'b1, we, a, en, d};
    n = 0;
    do begin
      #40 g = usb_gnt_out;
      @(negedge ref_clk_in);
      n++;
    end while (g !== 1'b1 && n < 8);
    `CHK("usb_gnt", 1'b1, g)
    {usb_req_in, usb_addr_in, usb_wdata_in} = {1'b0, ~a, ~d};
    @(negedge ref_clk_in);
  endtask : usb
  task automatic done(input logic [1:0] t, input logic [4:0] i);
    {usb_td_done_in, usb_td_type_in, usb_td_index_in} = {1'b1, t, i};
    if (t != 2'h3) exp_st[{t, i}] = 1'b1;
    @(negedge ref_clk_in);
    usb_td_done_in = 1'b0;
    `CHK("done_status", exp_st, done_status_out)
    @(negedge ref_clk_in);
  endtask : done
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // read answers are matched in issue order against the notes
  always @(negedge ref_clk_in) begin
    if (cpu_rvalid_out === 1'b1) begin
      e32 = cpu_q.pop_front();
      `CHK("cpu_rdata", e32, cpu_rdata_out)
    end
    if (usb_rvalid_out === 1'b1) begin
      e64 = usb_q.pop_front();
      `CHK("usb_rdata", e64, usb_rdata_out)
    end
  end
  initial begin
    #3000000 n_errors++;
    results();
  end
  initial begin
    void'($urandom(32'h57b82fd6));
    repeat (8) @(negedge ref_clk_in);
    reset_in = 1'b0;
    for (k = 0; k < 6; k++) cpu(1'b1, amap[k], $urandom);
    for (k = 0; k < 6; k++) cpu(1'b0, amap[k], 32'h0);
    $display("test regions done");
    cpu(1'b1, 16'h03fc, $urandom);
    cpu(1'b0, 16'h1002, 32'h0);
    $display("test refusals done");
    cpu(1'b1, 16'h1008, $urandom);
    cpu(1'b1, 16'h100c, $urandom);
    usb(1'b0, 13'h0181, 2'b11, 64'h0);
    usb(1'b0, 13'h1f7f, 2'b11, 64'h0);
    usb(1'b1, 13'h0182, 2'b11, {$urandom, $urandom});
    usb(1'b1, 13'h0182, 2'b01, {$urandom, $urandom});
    cpu(1'b0, 16'h1010, 32'h0);
    cpu(1'b0, 16'h1014, 32'h0);
    $display("test mapping done");
    for (k = 0; k < 3; k++) begin
      // a usb read just before leaves the last grant with usb, so the cpu wins the following ties
      if (k == 1) usb(1'b0, 13'h0182, 2'b11, 64'h0);
      fork
        cpu(1'b0, 16'h1008, 32'h0);
        begin
          // one cycle late, so usb meets the pending cpu slot
          @(negedge ref_clk_in);
          usb(1'b0, 13'h0181, 2'b11, 64'h0);
        end
      join
    end
    $display("test tie done");
    irq_or_mask_in[37] = 1'b1;
    done(2'h1, 5'h05);
    `CHK("irq_or", 1'b1, irq_out)
    {irq_or_mask_in[37], done_clear_in[37], exp_st[37]} = 3'b010;
    @(negedge ref_clk_in);
    done_clear_in[37] = 1'b0;
    @(negedge ref_clk_in);
    `CHK("irq_clear", 1'b0, irq_out)
    {irq_and_mask_in[0], irq_and_mask_in[64]} = 2'b11;
    done(2'h0, 5'h00);
    `CHK("irq_and_part", 1'b0, irq_out)
    done(2'h2, 5'h00);
    `CHK("irq_and_all", 1'b1, irq_out)
    done(2'h3, 5'h07);
    $display("test completion done");
    repeat (4) @(negedge ref_clk_in);
    `CHK("pending_reads", 0, cpu_q.size() + usb_q.size())
    results();
  end
endmodule : tb
